// ===== src/pci_side_interrupt_status_map.sv
// PCI side interrupt status, enable, routing and vector store
`timescale 1ns/1ps
`include "irq_map_defs.svh"
module pci_side_interrupt_status_map (
    input  wire logic        i_core_clk,            // 20 MHz core clock
    input  wire logic        i_rst_n,               // Async reset, low
    input  wire logic [11:0] i_addr,                // Register byte address
    input  wire logic [31:0] i_wr_data,             // Write data
    input  wire logic        i_wr_en,               // Write strobe
    input  wire logic        i_rd_en,               // Read strobe
    output logic [31:0]      o_rd_data,             // Read data, next cycle
    input  wire logic [3:0]  i_location_monitor_hit, // Monitor 3..0 events
    input  wire logic [3:0]  i_mailbox_write_event, // Mailbox 3..0 events
    input  wire logic        i_vme_soft_ack_event,  // Software ack event
    input  wire logic        i_vme_side_error,      // VME error event
    input  wire logic        i_pci_side_error,      // PCI error event
    input  wire logic        i_dma_done_event,      // DMA event
    input  wire logic        i_bus_ownership_event, // Ownership event
    input  wire logic        i_acfail_n,            // AC fail pin, low
    input  wire logic        i_sysfail_n,           // System fail pin, low
    input  wire logic [7:1]  i_vme_irq_level_line_n, // Level pins, low
    output logic             o_iack_req,            // Acknowledge request
    output logic [2:0]       o_iack_level,          // Level to acknowledge
    input  wire logic        i_iack_done,           // Acknowledge finished
    input  wire logic [7:0]  i_iack_vector,         // Fetched vector
    output logic [7:0]       o_pci_irq_out_pin,     // Routed pins, high
    output logic             o_irq                  // Any enabled status
);
    import irq_map_pkg::*;

    map_st_t     r_reg;
    map_st_t     r_next;
    logic        rst_meta_reg;
    logic        rst_sync_reg;
    logic [23:0] ev_raw;
    logic [23:0] ev_edge;
    logic [23:0] set_vec;
    logic [23:0] hold_vec;
    logic [23:0] clr_vec;
    logic [23:0] active;
    logic [7:0]  pin_calc;
    logic [7:1]  level_req;
    logic        wr_stat;
    logic        sw_rise;
    logic        seq_store;
    logic [7:0]  seq_vector;
    logic        iack_req_w;
    logic [2:0]  iack_level_w;

    // Field that routes status bit b; monitors and mailboxes use pin 0
    function automatic logic [2:0] route_of(input int unsigned b,
                                            input logic [31:0] ra,
                                            input logic [31:0] rb);
        logic [2:0] f;
        f = 3'h0;
        if (b < 8) begin
            f = ra[b*4 +: `ROUTE_FLD_W];
        end else if (b < 16) begin
            f = rb[(b-8)*4 +: `ROUTE_FLD_W];
        end
        return f;
    endfunction : route_of

    // Whether any active source is routed to pin p
    function automatic logic pin_hit(input int unsigned p,
                                     input logic [23:0] act,
                                     input logic [31:0] ra,
                                     input logic [31:0] rb);
        logic h;
        h = 1'b0;
        for (int unsigned b = 0; b < 24; b++) begin
            if (act[b] && route_of(b, ra, rb) == 3'(p)) begin
                h = 1'b1;
            end
        end
        return h;
    endfunction : pin_hit

    // Reset release through two flops, assertion stays asynchronous
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Same-clock event lines in status word order
    assign ev_raw = {i_location_monitor_hit, i_mailbox_write_event,
                     3'b000, i_vme_soft_ack_event, 1'b0,
                     i_vme_side_error, i_pci_side_error, i_dma_done_event,
                     7'h00, i_bus_ownership_event};
    assign ev_edge = ev_raw & ~r_reg.ev_prev;

    // Decoded write strobes
    assign wr_stat = i_wr_en && (i_addr == `OFF_STATUS ||
                                 i_addr == `OFF_CLEAR);
    assign sw_rise = i_wr_en && i_addr == `OFF_ENABLE &&
                     i_wr_data[`BIT_SWINT] && !r_reg.enable[`BIT_SWINT];
    assign clr_vec = wr_stat ? (i_wr_data[23:0] & `STAT_MASK)
                             : 24'h00_0000;

    // Fail pins hold their bits; a clear cannot beat an asserted pin
    assign hold_vec = {8'h00, r_reg.pin_sync[8:7], 14'h0000};

    // Setting terms: edges, fail levels, software rise, fetched levels
    always_comb begin
        set_vec = ev_edge;
        set_vec[`BIT_ACFAIL]  = r_reg.pin_sync[8];
        set_vec[`BIT_SYSFAIL] = r_reg.pin_sync[7];
        set_vec[`BIT_SWINT]   = sw_rise;
        if (seq_store && iack_level_w != 3'h0) begin
            set_vec[iack_level_w] = 1'b1;
        end
    end

    // Only enabled, active sources reach the pins
    assign active = r_reg.status & r_reg.enable;

    // One OR tree per output pin
    for (genvar p = 0; p < 8; p++) begin : g_pin
        assign pin_calc[p] = pin_hit(p, active, r_reg.route_a,
                                     r_reg.route_b);
    end

    // A level already latched is not fetched again until cleared
    assign level_req = r_reg.pin_sync[6:0] & r_reg.enable[7:1] &
                       ~r_reg.status[7:1];

    vme_iack_sequencer u_seq (
        .i_core_clk     (i_core_clk),
        .i_rst_n        (rst_sync_reg),
        .i_level_req    (level_req),
        .i_iack_done    (i_iack_done),
        .i_iack_vector  (i_iack_vector),
        .o_iack_req     (iack_req_w),
        .o_iack_level   (iack_level_w),
        .o_store        (seq_store),
        .o_store_vector (seq_vector)
    );

    // Next state of every register, pins and read port
    always_comb begin
        r_next = r_reg;
        r_next.pin_meta = {~i_acfail_n, ~i_sysfail_n,
                           ~i_vme_irq_level_line_n};
        r_next.pin_sync = r_reg.pin_meta;
        r_next.ev_prev  = ev_raw;
        // Set is ORed after the clear so a same-cycle event survives
        r_next.status = ((r_reg.status & ~(clr_vec & ~hold_vec))
                         | set_vec) & `STAT_MASK;
        if (i_wr_en) begin
            case (i_addr)
                `OFF_ENABLE:  r_next.enable  = i_wr_data[23:0] & `STAT_MASK;
                `OFF_ROUTE_A: r_next.route_a = i_wr_data & `ROUTE_A_MASK;
                `OFF_ROUTE_B: r_next.route_b = i_wr_data & `ROUTE_B_MASK;
                default: begin
                end
            endcase
        end
        if (seq_store && iack_level_w != 3'h0) begin
            r_next.vec[iack_level_w] = seq_vector;
        end
        // Read data live for one cycle only, zero otherwise
        r_next.rd_data = 32'h0000_0000;
        if (i_rd_en) begin
            case (i_addr)
                `OFF_ENABLE:  r_next.rd_data = {8'h00, r_reg.enable};
                `OFF_STATUS:  r_next.rd_data = {8'h00, r_reg.status};
                `OFF_ROUTE_A: r_next.rd_data = r_reg.route_a;
                `OFF_ROUTE_B: r_next.rd_data = r_reg.route_b;
                default: begin
                    if ((i_addr & `VEC_BLK_MASK) == `OFF_VEC_BASE &&
                        i_addr[4:2] != 3'h0) begin
                        r_next.rd_data = {24'h00_0000,
                                          r_reg.vec[i_addr[4:2]]};
                    end
                end
            endcase
        end
        r_next.pins = pin_calc;
        r_next.irq  = |active;
    end

    // Whole state in one register; reset clears status and routes
    always_ff @(posedge i_core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_rd_data         = r_reg.rd_data;
    assign o_pci_irq_out_pin = r_reg.pins;
    assign o_irq             = r_reg.irq;
    assign o_iack_req        = iack_req_w;
    assign o_iack_level      = iack_level_w;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!rst_sync_reg);

    // A latched bit with no clear aimed at it never drops
    property p_sticky;
        1 |=> ((($past(r_reg.status) & ~$past(clr_vec)) &
                ~r_reg.status) == 24'h00_0000);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("status bit dropped without a clear");

    // A status bit rises only through a set term, never on its own
    property p_no_stray;
        1 |=> ((r_reg.status & ~$past(r_reg.status) & ~$past(set_vec))
               == 24'h00_0000);
    endproperty
    a_no_stray: assert property (p_no_stray)
        else $error("status bit rose with no event");

    // Cleared bits with nothing setting or holding them read zero
    property p_w1c;
        1 |=> (($past(clr_vec) & ~$past(set_vec) & ~$past(hold_vec) &
                r_reg.status) == 24'h00_0000);
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write of one did not clear status");

    // Every set term lands, even against a clear
    property p_set_wins;
        1 |=> ((r_reg.status & $past(set_vec)) == $past(set_vec));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost in clearing cycle");

    // AC fail bit survives a clear while its pin is asserted
    property p_fail_hold;
        r_reg.pin_sync[8] && clr_vec[`BIT_ACFAIL] |=>
            r_reg.status[`BIT_ACFAIL];
    endproperty
    a_fail_hold: assert property (p_fail_hold)
        else $error("AC fail status cleared with pin asserted");

    // System fail bit survives a clear while its pin is asserted
    property p_sys_hold;
        r_reg.pin_sync[7] && clr_vec[`BIT_SYSFAIL] |=>
            r_reg.status[`BIT_SYSFAIL];
    endproperty
    a_sys_hold: assert property (p_sys_hold)
        else $error("system fail status cleared with pin asserted");

    // System fail pin asserted three cycles sets its bit
    property p_fail_level;
        !i_sysfail_n [*3] |=> r_reg.status[`BIT_SYSFAIL];
    endproperty
    a_fail_level: assert property (p_fail_level)
        else $error("system fail level not reflected");

    // Rising software enable sets the software status bit
    property p_sw_rise;
        sw_rise |=> r_reg.status[`BIT_SWINT];
    endproperty
    a_sw_rise: assert property (p_sw_rise)
        else $error("software interrupt not raised");

    // Ownership routed to pin 3 and active shows on that pin
    property p_route_own;
        active[0] && r_reg.route_a[2:0] == 3'h3 |=> o_pci_irq_out_pin[3];
    endproperty
    a_route_own: assert property (p_route_own)
        else $error("ownership interrupt not on its pin");

    // DMA routed to pin 5 and active shows on that pin
    property p_route_dma;
        active[8] && r_reg.route_b[2:0] == 3'h5 |=> o_pci_irq_out_pin[5];
    endproperty
    a_route_dma: assert property (p_route_dma)
        else $error("DMA interrupt not on its pin");

    // No active source routed anywhere means all pins low next
    property p_pins_quiet;
        active == 24'h00_0000 |=> o_pci_irq_out_pin == 8'h00;
    endproperty
    a_pins_quiet: assert property (p_pins_quiet)
        else $error("pin high with nothing enabled");

    // Interrupt line tracks any enabled, active source a cycle later
    property p_irq_level;
        1 |=> o_irq == ($past(active) != 24'h00_0000);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt line disagrees with enabled status");

    // Status read returns the status word in the next cycle
    property p_rd_status;
        i_rd_en && i_addr == `OFF_STATUS |=>
            o_rd_data == {8'h00, $past(r_reg.status)};
    endproperty
    a_rd_status: assert property (p_rd_status)
        else $error("status read mismatch");

    // Fetch completion, then the level bit is set a cycle later
    sequence s_fetch_done;
        seq_store && iack_level_w != 3'h0;
    endsequence
    property p_fetch_sets;
        s_fetch_done |=> r_reg.status[$past(iack_level_w)];
    endproperty
    a_fetch_sets: assert property (p_fetch_sets)
        else $error("fetched level not latched");

    // A new fetch never starts for a level still latched
    property p_no_refetch;
        $rose(o_iack_req) |-> !r_reg.status[o_iack_level];
    endproperty
    a_no_refetch: assert property (p_no_refetch)
        else $error("level fetched again while latched");

    // Right after reset release status and routes are zero
    property p_reset_zero;
        $rose(rst_sync_reg) |-> r_reg.status == `STAT_RESET &&
            r_reg.route_a == `ROUTE_RESET && r_reg.route_b == `ROUTE_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("state not zero after reset");

endmodule : pci_side_interrupt_status_map

// ===== src/irq_map_defs.svh
// Offsets, field positions, masks and reset values of the interrupt map
`ifndef IRQ_MAP_DEFS_SVH
`define IRQ_MAP_DEFS_SVH

`define OFF_ENABLE    12'h300
`define OFF_STATUS    12'h304
`define OFF_ROUTE_A   12'h308
`define OFF_ROUTE_B   12'h30C
`define OFF_CLEAR     12'h318
`define OFF_VEC_BASE  12'h320
`define VEC_BLK_MASK  12'hFE0

`define STAT_MASK     24'hFF_F7FF
`define ROUTE_A_MASK  32'h7777_7777
`define ROUTE_B_MASK  32'h7777_0777
`define STAT_RESET    24'h00_0000
`define ROUTE_RESET   32'h0000_0000

`define BIT_ACFAIL    15
`define BIT_SYSFAIL   14
`define BIT_SWINT     13
`define ROUTE_FLD_W   3

`endif

// ===== src/irq_map_pkg.sv
// Types shared by the interrupt status and routing block
package irq_map_pkg;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_BUSY, SEQ_SETTLE} seq_state_t;

    typedef struct packed {
        seq_state_t  state;
        logic        req;
        logic [2:0]  level;
        logic        store;
        logic [7:0]  vector;
    } seq_st_t;

    typedef struct packed {
        logic [8:0]       pin_meta;
        logic [8:0]       pin_sync;
        logic [23:0]      ev_prev;
        logic [23:0]      status;
        logic [23:0]      enable;
        logic [31:0]      route_a;
        logic [31:0]      route_b;
        logic [7:1][7:0]  vec;
        logic [31:0]      rd_data;
        logic [7:0]       pins;
        logic             irq;
    } map_st_t;

endpackage : irq_map_pkg

// ===== src/vme_iack_sequencer.sv
// Acknowledge sequencer that fetches one vector per asserted level
`timescale 1ns/1ps
module vme_iack_sequencer (
    input  wire logic       i_core_clk,      // Core clock
    input  wire logic       i_rst_n,         // Synchronised reset, low
    input  wire logic [7:1] i_level_req,     // Levels needing a fetch
    input  wire logic       i_iack_done,     // Acknowledge cycle done
    input  wire logic [7:0] i_iack_vector,   // Vector from that cycle
    output logic            o_iack_req,      // Acknowledge request
    output logic [2:0]      o_iack_level,    // Level being acknowledged
    output logic            o_store,         // Vector ready, one cycle
    output logic [7:0]      o_store_vector   // Vector to keep
);
    import irq_map_pkg::*;

    seq_st_t r_reg;
    seq_st_t r_next;

    // Highest requesting level wins
    function automatic logic [2:0] top_level(input logic [7:1] req);
        logic [2:0] lv;
        lv = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (req[i]) begin
                lv = 3'(i);
            end
        end
        return lv;
    endfunction : top_level

    // Settle state lets the status bit land before the next look
    always_comb begin
        r_next = r_reg;
        r_next.store = 1'b0;
        case (r_reg.state)
            SEQ_IDLE: begin
                if (|i_level_req) begin
                    r_next.state = SEQ_BUSY;
                    r_next.req = 1'b1;
                    r_next.level = top_level(i_level_req);
                end
            end
            SEQ_BUSY: begin
                if (i_iack_done) begin
                    r_next.state = SEQ_SETTLE;
                    r_next.req = 1'b0;
                    r_next.store = 1'b1;
                    r_next.vector = i_iack_vector;
                end
            end
            SEQ_SETTLE: begin
                r_next.state = SEQ_IDLE;
            end
            default: begin
                r_next.state = SEQ_IDLE;
                r_next.req = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_iack_req     = r_reg.req;
    assign o_iack_level   = r_reg.level;
    assign o_store        = r_reg.store;
    assign o_store_vector = r_reg.vector;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    // Request holds with a steady level until the cycle completes
    property p_req_hold;
        o_iack_req && !i_iack_done |=> o_iack_req && $stable(o_iack_level);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("acknowledge request dropped early");

    // Completion yields one store pulse and a gap of two cycles
    property p_store_once;
        o_iack_req && i_iack_done |=> o_store ##1 !o_store && !o_iack_req;
    endproperty
    a_store_once: assert property (p_store_once)
        else $error("vector store pulse malformed");

endmodule : vme_iack_sequencer

// ===== dv/iack_responder.sv
// Far bus model that answers acknowledge requests with a vector
`timescale 1ns/1ps
module iack_responder (
    input  wire logic       i_core_clk,    // Core clock
    input  wire logic       i_iack_req,    // Acknowledge wanted
    input  wire logic [2:0] i_iack_level,  // Level asked for
    input  wire logic [3:0] i_delay,       // Cycles before answering
    output logic            o_iack_done,   // Cycle finished, one pulse
    output logic [7:0]      o_iack_vector  // Vector, valid with done
);
    logic [3:0] wait_cnt;

    // Quiet bus at time zero
    initial begin
        o_iack_done = 1'b0;
        o_iack_vector = 8'h00;
        wait_cnt = 4'h0;
    end

    // One vector per fetch, after a chosen wait
    always @(posedge i_core_clk) begin
        if (i_iack_req && !o_iack_done && wait_cnt == i_delay) begin
            o_iack_done <= 1'b1;
            o_iack_vector <= {5'h15, i_iack_level};
            wait_cnt <= 4'h0;
        end else begin
            o_iack_done <= 1'b0;
            // Released bus toggles so a stale vector never looks valid
            o_iack_vector <= ~o_iack_vector;
            if (i_iack_req && !o_iack_done) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule : iack_responder

// ===== dv/pci_side_interrupt_status_map_bench.sv
// Self-checking bench for the interrupt status and routing block
`timescale 1ns/1ps
`include "irq_map_defs.svh"
module pci_side_interrupt_status_map_bench;
    logic        core_clk;
    logic        rst_n;
    logic [11:0] addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rd_data;
    logic [23:0] ev;
    logic        acfail_n;
    logic        sysfail_n;
    logic [7:1]  lvl_n;
    logic        iack_req;
    logic [2:0]  iack_level;
    logic        iack_done;
    logic [7:0]  iack_vec;
    logic [3:0]  delay;
    logic [7:0]  pins;
    logic        irq;
    int          n_errors;
    int          check_count;

    pci_side_interrupt_status_map u_dut (
        .i_core_clk(core_clk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wr_data(wr_data), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .o_rd_data(rd_data), .i_location_monitor_hit(ev[23:20]),
        .i_mailbox_write_event(ev[19:16]), .i_vme_soft_ack_event(ev[12]),
        .i_vme_side_error(ev[10]), .i_pci_side_error(ev[9]),
        .i_dma_done_event(ev[8]), .i_bus_ownership_event(ev[0]),
        .i_acfail_n(acfail_n), .i_sysfail_n(sysfail_n),
        .i_vme_irq_level_line_n(lvl_n), .o_iack_req(iack_req),
        .o_iack_level(iack_level), .i_iack_done(iack_done),
        .i_iack_vector(iack_vec), .o_pci_irq_out_pin(pins), .o_irq(irq));

    iack_responder u_far (
        .i_core_clk(core_clk), .i_iack_req(iack_req),
        .i_iack_level(iack_level), .i_delay(delay),
        .o_iack_done(iack_done), .o_iack_vector(iack_vec));

    // 20 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask : rdc

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task automatic pulse(input int i);
        @(posedge core_clk);
        ev[i] <= 1'b1;
        @(posedge core_clk);
        ev[i] <= 1'b0;
    endtask : pulse

    task automatic t_regs();
        rdc(`OFF_STATUS, 32'h0000_0000);
        rdc(`OFF_ROUTE_A, 32'h0000_0000);
        rdc(`OFF_ROUTE_B, 32'h0000_0000);
        wr(`OFF_ROUTE_A, 32'hFFFF_FFFF);
        rdc(`OFF_ROUTE_A, 32'h7777_7777);
        wr(`OFF_ROUTE_B, 32'hFFFF_FFFF);
        rdc(`OFF_ROUTE_B, 32'h7777_0777);
        // Unmapped place reads zero and swallows writes
        wr(12'h3F0, 32'hFFFF_FFFF);
        rdc(12'h3F0, 32'h0000_0000);
        wr(`OFF_ROUTE_A, 32'h0000_0000);
        wr(`OFF_ROUTE_B, 32'h0000_0000);
    endtask : t_regs

    // Every edge source lands on its own bit and clears by one
    task automatic t_events();
        logic [23:0] m;
        m = 24'hFF_1701;
        for (int i = 0; i < 24; i++) begin
            if (m[i]) begin
                pulse(i);
                cyc(2);
                rdc(`OFF_STATUS, 32'h1 << i);
                wr(`OFF_STATUS, 32'h0000_0000);
                rdc(`OFF_STATUS, 32'h1 << i);
                wr(`OFF_STATUS, 32'h1 << i);
                rdc(`OFF_STATUS, 32'h0000_0000);
            end
        end
    endtask : t_events

    task automatic t_swint();
        wr(`OFF_ENABLE, 32'h0000_2000);
        rdc(`OFF_STATUS, 32'h0000_2000);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        wr(`OFF_ENABLE, 32'hFFFF_FFFF);
        rdc(`OFF_ENABLE, 32'h00FF_F7FF);
        wr(`OFF_ENABLE, 32'h0000_0000);
        cyc(3);
        chk({31'h0, irq}, 32'h0);
        rdc(`OFF_STATUS, 32'h0000_2000);
        wr(`OFF_STATUS, 32'h0000_2000);
    endtask : t_swint

    task automatic t_route();
        wr(`OFF_ROUTE_B, 32'h0000_0005);
        wr(`OFF_ENABLE, 32'h0000_0100);
        pulse(8);
        cyc(3);
        chk({24'h0, pins}, 32'h0000_0020);
        wr(`OFF_ROUTE_B, 32'h0000_0000);
        cyc(3);
        chk({24'h0, pins}, 32'h0000_0001);
        wr(`OFF_ENABLE, 32'h0000_0000);
        cyc(3);
        chk({24'h0, pins}, 32'h0000_0000);
        wr(`OFF_ENABLE, 32'h0000_0100);
        wr(`OFF_STATUS, 32'h0000_0100);
        cyc(3);
        chk({24'h0, pins}, 32'h0000_0000);
        // Ownership on pin 3, then cleared through the clear alias
        wr(`OFF_ROUTE_A, 32'h0000_0003);
        wr(`OFF_ENABLE, 32'h0000_0001);
        pulse(0);
        cyc(3);
        chk({24'h0, pins}, 32'h0000_0008);
        chk({31'h0, irq}, 32'h1);
        wr(`OFF_CLEAR, 32'h0000_0001);
        cyc(3);
        chk({24'h0, pins}, 32'h0000_0000);
        rdc(`OFF_STATUS, 32'h0000_0000);
        wr(`OFF_ROUTE_A, 32'h0000_0000);
        wr(`OFF_ENABLE, 32'h0000_0000);
    endtask : t_route

    // Fail bits cannot be cleared while their pins stay low
    task automatic t_fail();
        @(posedge core_clk);
        acfail_n <= 1'b0;
        sysfail_n <= 1'b0;
        cyc(6);
        rdc(`OFF_STATUS, 32'h0000_C000);
        wr(`OFF_STATUS, 32'h0000_C000);
        rdc(`OFF_STATUS, 32'h0000_C000);
        @(posedge core_clk);
        acfail_n <= 1'b1;
        sysfail_n <= 1'b1;
        cyc(6);
        wr(`OFF_STATUS, 32'h0000_C000);
        rdc(`OFF_STATUS, 32'h0000_0000);
    endtask : t_fail

    task automatic t_clash();
        pulse(9);
        @(posedge core_clk);
        addr <= `OFF_STATUS;
        wr_data <= 32'h0000_0200;
        wr_en <= 1'b1;
        ev[9] <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
        ev[9] <= 1'b0;
        rdc(`OFF_STATUS, 32'h0000_0200);
        wr(`OFF_STATUS, 32'h0000_0200);
    endtask : t_clash

    // Level fetch, vector store, no second fetch while status is set
    task automatic t_level(input logic [2:0] lv, input logic [3:0] dly,
                           input logic [31:0] rt, input logic [7:0] pn);
        int   n;
        logic seen;
        delay <= dly;
        wr(`OFF_ROUTE_A, rt);
        wr(`OFF_ENABLE, 32'h1 << lv);
        lvl_n[lv] <= 1'b0;
        n = 0;
        while (iack_req !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk({31'h0, iack_req}, 32'h1);
        chk({29'h0, iack_level}, {29'h0, lv});
        n = 0;
        while (iack_req !== 1'b0 && n < 40) begin
            cyc(1);
            n++;
        end
        chk({31'h0, iack_req}, 32'h0);
        cyc(3);
        rdc(`OFF_STATUS, 32'h1 << lv);
        rdc(`OFF_VEC_BASE + 12'(4 * lv), {24'h0, 5'h15, lv});
        chk({24'h0, pins}, {24'h0, pn});
        seen = 1'b0;
        repeat (12) begin
            cyc(1);
            seen = seen | (iack_req !== 1'b0);
        end
        chk({31'h0, seen}, 32'h0);
        @(posedge core_clk);
        lvl_n[lv] <= 1'b1;
        cyc(4);
        wr(`OFF_STATUS, 32'h1 << lv);
        rdc(`OFF_STATUS, 32'h0000_0000);
        wr(`OFF_ENABLE, 32'h0000_0000);
    endtask : t_level

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        wrap_up();
    end

    // Main sequence
    initial begin
        n_errors = 0;
        check_count = 0;
        rst_n = 1'b0;
        addr = 12'h000;
        wr_data = 32'h0000_0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        ev = 24'h00_0000;
        acfail_n = 1'b1;
        sysfail_n = 1'b1;
        lvl_n = 7'h7F;
        delay = 4'h0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_regs();
        t_events();
        t_swint();
        t_route();
        t_fail();
        t_clash();
        t_level(3'd3, 4'd4, 32'h0000_2000, 8'h04);
        t_level(3'd7, 4'd0, 32'h7000_0000, 8'h80);
        wrap_up();
    end
endmodule : pci_side_interrupt_status_map_bench
